// File: verilog/hdma_defs.svh
// Constants of the host memory access port: offsets, fields, encodings.
// Assumes inclusion by bare name from the package and the port module.
`ifndef HDMA_DEFS_SVH
`define HDMA_DEFS_SVH

`define HDMA_BUS_W 16
`define HDMA_ADDR_W 14
`define HDMA_WORD_W 24
`define HDMA_CW_OVL_BIT 15
`define HDMA_CW_TYPE_BIT 14
`define HDMA_TYPE_DM 1'b1
`define HDMA_OVL_ADDR 14'h3FE0
`define HDMA_SYSCTL_ADDR 14'h3FE7
`define HDMA_SHORTRD_BIT 14
`define HDMA_MMR_BASE 14'h3FE0
`define HDMA_BOOT_STRAP 3'h5
`define HDMA_BOOT_PM_ADDR 14'h0000
`define HDMA_ADDR_STEP 14'h0001
`define HDMA_OVL_RST 16'h0000
`define HDMA_PAD_BYTE 8'h00

`endif

// File: verilog/hdma_pkg.sv
// Types shared by the host memory access port modules.
// Assumes hdma_defs.svh is on the include path.
`include "hdma_defs.svh"
package hdma_pkg;

  // One-hot port sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_RDMEM = 3'h2,
    ST_RDOUT = 3'h4
  } hdma_state_e;

  // Write request queued toward memory
  typedef struct packed {
    logic pm;
    logic [`HDMA_ADDR_W-1:0] addr;
    logic [`HDMA_WORD_W-1:0] data;
  } hdma_wreq_s;

endpackage

// File: verilog/hdma_sync.sv
// Two-flop synchroniser bank for asynchronous host pins and straps.
// Assumes each bit is a level that stays put for several clocks.
`timescale 1ns/1ns
`default_nettype none
module hdma_sync
  import hdma_pkg::*;
#(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Raw and synchronised levels
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  // Both stages in one packed record
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } hdma_sync_s;

  hdma_sync_s s_q;
  hdma_sync_s s_d;

  // First stage feeds only the second
  always_comb begin
    s_d.meta = din;
    s_d.sync = s_q.meta;
  end

  // Idle-high reset keeps low-active strobes inactive
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      s_q <= '1;
    end else begin
      s_q <= s_d;
    end
  end

  assign dout = s_q.sync;
endmodule // hdma_sync
`default_nettype wire

// File: verilog/hdma_buf.sv
// Small ready/valid buffer between host writes and memory slots.
// Assumes the drain side may stall for any number of cycles.
`timescale 1ns/1ns
`default_nettype none
module hdma_buf
  import hdma_pkg::*;
#(
  parameter int W = 39,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);

  // Storage, pointers and fill count
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } hdma_buf_s;

  hdma_buf_s s_q;
  hdma_buf_s s_d;
  logic push;
  logic pop;

  // Honest full and empty from the count
  assign in_ready = (s_q.cnt != (PW+1)'(DEPTH));
  assign out_valid = (s_q.cnt != '0);
  assign out_data = s_q.mem[s_q.rp];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Pointer wrap works for any depth of two or more, not only powers of two
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wp] = in_data;
      s_d.wp = (s_q.wp == PW'(DEPTH-1)) ? '0 : s_q.wp + PW'(1);
    end
    if (pop) begin
      s_d.rp = (s_q.rp == PW'(DEPTH-1)) ? '0 : s_q.rp + PW'(1);
    end
    s_d.cnt = s_q.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  // Registered state
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule // hdma_buf
`default_nettype wire

// File: verilog/hdma_port.sv
// Host memory access port: asynchronous host pins to on-chip memory.
// Assumes the core grants one memory slot per request, read data
// valid in the grant cycle, and a host that waits on acknowledge.
`timescale 1ns/1ns
`default_nettype none
`include "hdma_defs.svh"
module hdma_port
  import hdma_pkg::*;
#(
  parameter int BUF_DEPTH = 2
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Host control pins, asynchronous
  input wire logic port_select_n,
  input wire logic address_latch_strobe,
  input wire logic port_read_strobe_n,
  input wire logic port_write_strobe_n,
  // Multiplexed address/data bus, split three ways
  input wire logic [15:0] multiplexed_ad_bus_in,
  output logic [15:0] multiplexed_ad_bus_out,
  output logic multiplexed_ad_bus_oe,
  // Host acknowledge, low when the port can take an operation
  output logic access_ack_n,
  // Boot straps, sampled once after reset
  input wire logic mode_a,
  input wire logic mode_b,
  input wire logic mode_c,
  // Memory slot toward the core
  output logic mem_req,
  output logic mem_we,
  output logic mem_pm,
  output logic [13:0] mem_addr,
  output logic [23:0] mem_wdata,
  input wire logic mem_grant,
  input wire logic [23:0] mem_rdata,
  // Core data-memory writes and control-word write
  input wire logic core_dm_we,
  input wire logic [13:0] core_dm_addr,
  input wire logic [15:0] core_dm_wdata,
  input wire logic core_ctrl_we,
  // Overlay selection and boot hold toward the core
  output logic [15:0] overlay_sel,
  output logic core_hold
);

  localparam int REQ_W = $bits(hdma_wreq_s);

  // Whole port state in one record
  typedef struct packed {
    hdma_state_e st;
    logic sel_p;        // Previous synced select, low active
    logic ale_p;        // Previous synced latch strobe
    logic rd_p;         // Previous synced read strobe
    logic wr_p;         // Previous synced write strobe
    logic [13:0] addr;  // Start address latch, never read back
    logic dm;           // Target type of the latched address
    logic half;         // Second half of a program word pending
    logic [15:0] pm_hi; // Upper 16 bits of a program word
    logic [7:0] pm_lo;  // Lower 8 bits kept from a program read
    logic [15:0] rdata; // Data driven on the bus
    logic oe;           // Bus drive enable
    logic ack_n;        // Acknowledge pin
    logic push;         // Write request offered to the buffer
    hdma_wreq_s preq;   // Write request payload
    logic mreq;         // Memory slot request
    logic mwe;
    logic mpm;
    logic [13:0] maddr;
    logic [23:0] mwdata;
    logic [15:0] ovl;   // Overlay register
    logic short_rd;     // Short read timing select
    logic [1:0] strap_age; // Sync settle count, straps not yet valid
    logic strap_done;   // Straps already sampled
    logic hold;         // Registered core hold
    logic boot;         // Booting through this port
    logic pm0_done;     // Program word zero written
  } hdma_port_s;

  hdma_port_s s_q;
  hdma_port_s s_d;

  // Synchronised pin levels
  logic [22:0] sync_in;
  logic [22:0] sync_out;
  logic sel_s;
  logic ale_s;
  logic rd_s;
  logic wr_s;
  logic [15:0] ad_s;
  logic [2:0] strap_s;

  // Buffer handshake
  logic buf_in_ready;
  logic buf_out_valid;
  logic buf_out_ready;
  logic [REQ_W-1:0] buf_out_data;
  hdma_wreq_s head;

  // Edge events derived from synced levels
  logic latch_ev;
  logic rd_ev;
  logic wr_ev;
  logic rd_end;
  logic writes_idle;

  // Control-registers area is off limits to host writes
  function automatic logic is_mmr(input logic dm,
                                  input logic [13:0] a);
    is_mmr = (dm == `HDMA_TYPE_DM) && (a >= `HDMA_MMR_BASE);
  endfunction

  // Program word zero is the boot release location
  function automatic logic is_boot_word(input logic pm,
                                        input logic [13:0] a);
    is_boot_word = pm && (a == `HDMA_BOOT_PM_ADDR);
  endfunction

  // Every host pin and strap passes two flops first
  assign sync_in = {port_select_n, address_latch_strobe,
                    port_read_strobe_n, port_write_strobe_n,
                    multiplexed_ad_bus_in, mode_c, mode_b, mode_a};

  hdma_sync #(.W(23)) u_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .din(sync_in),
    .dout(sync_out)
  );

  assign {sel_s, ale_s, rd_s, wr_s, ad_s, strap_s} = sync_out;

  // Write requests queue here so a stalled slot loses nothing
  hdma_buf #(.W(REQ_W), .DEPTH(BUF_DEPTH)) u_buf (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .in_valid(s_q.push),
    .in_ready(buf_in_ready),
    .in_data(s_q.preq),
    .out_valid(buf_out_valid),
    .out_ready(buf_out_ready),
    .out_data(buf_out_data)
  );

  assign head = hdma_wreq_s'(buf_out_data);
  // Pop the head when the memory slot is free
  assign buf_out_ready = !s_q.mreq;

  // Latch on strobe fall under select, or select trailing edge
  assign latch_ev = (s_q.ale_p && !ale_s && !sel_s) ||
                    (!s_q.sel_p && sel_s && ale_s);
  // Read starts on strobe fall under select
  assign rd_ev = s_q.rd_p && !rd_s && !sel_s && !ale_s;
  // Write data taken on strobe trailing edge under select
  assign wr_ev = !s_q.wr_p && wr_s && !s_q.sel_p && !ale_s;
  // Read ends when either strobe or select is released
  assign rd_end = rd_s || sel_s;
  // Reads wait behind earlier writes to keep order
  assign writes_idle = !buf_out_valid && !s_q.push && !s_q.mreq;

  // Next-state logic
  always_comb begin
    s_d = s_q;
    s_d.sel_p = sel_s;
    s_d.ale_p = ale_s;
    s_d.rd_p = rd_s;
    s_d.wr_p = wr_s;
    s_d.push = 1'b0;

    // Straps sampled once the sync stages no longer show reset ones
    s_d.strap_age = {s_q.strap_age[0], 1'b1};
    if (s_q.strap_age[1] && !s_q.strap_done) begin
      s_d.strap_done = 1'b1;
      s_d.boot = (strap_s == `HDMA_BOOT_STRAP);
    end

    // Core writes: overlay and system control bit
    if (core_dm_we && core_dm_addr == `HDMA_OVL_ADDR) begin
      s_d.ovl = core_dm_wdata;
    end
    if (core_dm_we && core_dm_addr == `HDMA_SYSCTL_ADDR) begin
      s_d.short_rd = core_dm_wdata[`HDMA_SHORTRD_BIT];
    end
    // Core loads the start address like the host does
    if (core_ctrl_we && !core_dm_wdata[`HDMA_CW_OVL_BIT]) begin
      s_d.addr = core_dm_wdata[13:0];
      s_d.dm = core_dm_wdata[`HDMA_CW_TYPE_BIT];
      s_d.half = 1'b0;
    end else if (core_ctrl_we) begin
      s_d.ovl = {8'h00, core_dm_wdata[7:0]};
    end

    // Memory slot: finish the granted access first
    if (s_q.mreq && mem_grant) begin
      s_d.mreq = 1'b0;
      if (s_q.mwe && is_boot_word(s_q.mpm, s_q.maddr)) begin
        s_d.pm0_done = 1'b1;
      end
    end
    // Then fill a free slot from the write queue
    if (!s_q.mreq && buf_out_valid) begin
      s_d.mreq = 1'b1;
      s_d.mwe = 1'b1;
      s_d.mpm = head.pm;
      s_d.maddr = head.addr;
      s_d.mwdata = head.data;
    end

    case (s_q.st)
      // Waiting for a host operation
      ST_IDLE: begin
        if (latch_ev && ad_s[`HDMA_CW_OVL_BIT]) begin
          // Host overrides a same-cycle core overlay write
          s_d.ovl = {8'h00, ad_s[7:0]};
        end else if (latch_ev) begin
          s_d.addr = ad_s[13:0];
          s_d.dm = ad_s[`HDMA_CW_TYPE_BIT];
          s_d.half = 1'b0;
        end else if (wr_ev && !s_q.dm && !s_q.half) begin
          // Upper program bits wait for the second write
          s_d.pm_hi = ad_s;
          s_d.half = 1'b1;
        end else if (wr_ev) begin
          // Control-register area is dropped, address still steps
          s_d.push = !is_mmr(s_q.dm, s_q.addr);
          s_d.preq.pm = !s_q.dm;
          s_d.preq.addr = s_q.addr;
          s_d.preq.data = s_q.dm ? {`HDMA_PAD_BYTE, ad_s} :
                                   {s_q.pm_hi, ad_s[7:0]};
          s_d.half = 1'b0;
          s_d.addr = s_q.addr + `HDMA_ADDR_STEP;
        end else if (rd_ev && !s_q.dm && s_q.half) begin
          // Lower program byte is already held, no memory cycle
          s_d.rdata = {`HDMA_PAD_BYTE, s_q.pm_lo};
          s_d.oe = 1'b1;
          s_d.half = 1'b0;
          s_d.addr = s_q.addr + `HDMA_ADDR_STEP;
          s_d.st = ST_RDOUT;
        end else if (rd_ev) begin
          s_d.st = ST_RDMEM;
        end
      end
      // Waiting for queued writes, then for the read slot
      ST_RDMEM: begin
        if (s_q.mreq && mem_grant && !s_q.mwe) begin
          s_d.rdata = s_q.dm ? mem_rdata[15:0] : mem_rdata[23:8];
          s_d.pm_lo = mem_rdata[7:0];
          s_d.oe = 1'b1;
          // Program reads step only after the low byte
          s_d.half = !s_q.dm;
          if (s_q.dm) begin
            s_d.addr = s_q.addr + `HDMA_ADDR_STEP;
          end
          s_d.st = ST_RDOUT;
        end else if (!s_q.mreq && writes_idle) begin
          s_d.mreq = 1'b1;
          s_d.mwe = 1'b0;
          s_d.mpm = !s_q.dm;
          s_d.maddr = s_q.addr;
        end
      end
      // Driving read data until the host lets go
      ST_RDOUT: begin
        if (rd_end) begin
          s_d.oe = 1'b0;
          s_d.st = ST_IDLE;
        end
      end
      default: begin
        s_d.st = ST_IDLE;
        s_d.oe = 1'b0;
      end
    endcase

    // Acknowledge only in idle or read-out, with buffer room and no push or host event pending
    s_d.ack_n = !((s_d.st == ST_IDLE || s_d.st == ST_RDOUT) &&
                  buf_in_ready && !s_d.push && !s_q.push &&
                  !latch_ev && !wr_ev && !rd_ev);
    // Long short-read timing forces acknowledge high on the low-byte rd_ev, which already holds it high
    if (rd_ev && !s_q.dm && s_q.half && !s_q.short_rd) begin
      s_d.ack_n = 1'b1;
    end
    // Hold from a flop; also high until the straps are sampled
    s_d.hold = !s_d.strap_done || (s_d.boot && !s_d.pm0_done);
  end

  // Registered state, synchronous active-low reset
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
      s_q.sel_p <= 1'b1;
      s_q.rd_p <= 1'b1;
      s_q.wr_p <= 1'b1;
      s_q.ack_n <= 1'b1;
      s_q.hold <= 1'b1;
      s_q.ovl <= `HDMA_OVL_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state record; address never on bus
  assign multiplexed_ad_bus_out = s_q.rdata;
  assign multiplexed_ad_bus_oe = s_q.oe;
  assign access_ack_n = s_q.ack_n;
  assign mem_req = s_q.mreq;
  assign mem_we = s_q.mwe;
  assign mem_pm = s_q.mpm;
  assign mem_addr = s_q.maddr;
  assign mem_wdata = s_q.mwdata;
  assign overlay_sel = s_q.ovl;
  // Hold also covers the strap settling cycles after reset
  assign core_hold = s_q.hold;

endmodule // hdma_port
`default_nettype wire

// File: verif/hdma_port_monitor.sv
// Assertion checker for the host memory access port top.
// Assumes it is bound to hdma_port and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module hdma_port_monitor (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Host side
  input wire logic port_read_strobe_n,
  input wire logic [15:0] multiplexed_ad_bus_out,
  input wire logic multiplexed_ad_bus_oe,
  input wire logic access_ack_n,
  // Memory slot
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic mem_pm,
  input wire logic [13:0] mem_addr,
  input wire logic [23:0] mem_wdata,
  input wire logic mem_grant,
  input wire logic [23:0] mem_rdata,
  // Core side
  input wire logic core_dm_we,
  input wire logic [13:0] core_dm_addr,
  input wire logic [15:0] core_dm_wdata,
  input wire logic core_ctrl_we,
  input wire logic [15:0] overlay_sel,
  input wire logic core_hold
);
  // One domain, so one clock and one disable for all but the reset check
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // Reset must leave the port quiet; checked even during reset
  property p_reset_idle;
    disable iff (1'b0)
    !nrst |=> access_ack_n && !multiplexed_ad_bus_oe && !mem_req
      && core_hold && overlay_sel == 16'h0000;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("Port not idle after reset");

  // Request held steady until the slot is granted
  property p_req_hold;
    mem_req && !mem_grant |=> mem_req && $stable(mem_addr)
      && $stable(mem_we) && $stable(mem_wdata);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("Memory request changed before grant");

  // Control register range never written from the host
  property p_no_mmr;
    mem_req && mem_we && !mem_pm |-> mem_addr < 14'h3FE0;
  endproperty
  a_no_mmr: assert property (p_no_mmr)
    else $error("Write toward control register range");

  // Busy while a read waits for memory
  property p_rd_busy;
    mem_req && !mem_we |-> access_ack_n;
  endproperty
  a_rd_busy: assert property (p_rd_busy)
    else $error("Acknowledge low while read pending");

  // Granted read shows on the bus next cycle
  property p_rd_data;
    mem_req && mem_grant && !mem_we |=> multiplexed_ad_bus_oe
      && multiplexed_ad_bus_out == ($past(mem_pm) ?
      $past(mem_rdata[23:8]) : $past(mem_rdata[15:0]));
  endproperty
  a_rd_data: assert property (p_rd_data)
    else $error("Read data not driven after grant");

  // Core write at the overlay address lands in the register
  property p_ovl_core;
    core_dm_we && !core_ctrl_we && core_dm_addr == 14'h3FE0
      |=> overlay_sel == $past(core_dm_wdata);
  endproperty
  a_ovl_core: assert property (p_ovl_core)
    else $error("Overlay register missed core write");

  // Bus released once the read strobe has been high a while
  property p_oe_off;
    port_read_strobe_n [*5] |-> !multiplexed_ad_bus_oe;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("Bus still driven after read ended");

  // Boot hold lifts after program word zero is written
  property p_boot_release;
    core_hold && mem_req && mem_grant && mem_we && mem_pm
      && mem_addr == 14'h0000 |-> ##[1:2] !core_hold;
  endproperty
  a_boot_release: assert property (p_boot_release)
    else $error("Core still held after word zero");
endmodule // hdma_port_monitor

bind hdma_port hdma_port_monitor u_mon (
  .sys_clk, .nrst, .port_read_strobe_n, .multiplexed_ad_bus_out,
  .multiplexed_ad_bus_oe, .access_ack_n, .mem_req, .mem_we, .mem_pm,
  .mem_addr, .mem_wdata, .mem_grant, .mem_rdata, .core_dm_we,
  .core_dm_addr, .core_dm_wdata, .core_ctrl_we, .overlay_sel, .core_hold
);
`default_nettype wire

// File: verif/hdma_mem_model.sv
// Behavioural on-chip memory answering the port's memory slot.
// Assumes one request at a time; grant delay set by the bench.
`timescale 1ns/1ns
`default_nettype none
module hdma_mem_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Memory slot from the port
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic mem_pm,
  input wire logic [13:0] mem_addr,
  input wire logic [23:0] mem_wdata,
  output logic mem_grant,
  output logic [23:0] mem_rdata,
  // Grant delay in cycles
  input wire logic [7:0] lat
);
  logic [23:0] pm_mem [0:16383]; // Program words
  logic [23:0] dm_mem [0:16383]; // Data words, low 16 bits used
  logic [7:0] wait_q; // Cycles spent stalling
  // Cleared so an unwanted write is visible
  initial begin
    for (int i = 0; i < 16384; i++) begin
      pm_mem[i] = 24'h000000;
      dm_mem[i] = 24'h000000;
    end
  end
  // Read data toggles outside the grant cycle so stale use shows
  always @(posedge sys_clk) begin
    if (!nrst) begin
      mem_grant <= 1'b0;
      wait_q <= 8'h00;
      mem_rdata <= 24'hA5A5A5;
    end else if (mem_grant) begin
      mem_grant <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_q <= 8'h00;
      if (mem_req && mem_we && mem_pm) pm_mem[mem_addr] <= mem_wdata;
      if (mem_req && mem_we && !mem_pm) dm_mem[mem_addr] <= mem_wdata;
    end else if (mem_req && wait_q >= lat) begin
      mem_grant <= 1'b1;
      mem_rdata <= mem_pm ? pm_mem[mem_addr] : dm_mem[mem_addr];
    end else begin
      mem_rdata <= ~mem_rdata;
      if (mem_req) wait_q <= wait_q + 8'h01;
    end
  end
endmodule // hdma_mem_model
`default_nettype wire

// File: verif/tb_top.sv
// Self-checking bench for the host memory access port.
// Assumes hdma_mem_model answers the memory slot.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  // Host pins, core side and memory slot
  logic sys_clk, nrst, sel_n, ale, rd_n, wr_n, oe, ack_n, hold;
  logic req, we, pm, grant, cdm_we, cctl_we;
  logic [15:0] ad_in, bus_out, ovl, cdm_wdata, rd_v;
  logic [13:0] maddr, cdm_addr;
  logic [23:0] wdata, rdata;
  logic [7:0] lat;
  int errors, cmp_count;

  // Straps tied to host boot pattern
  hdma_port #(.BUF_DEPTH(2)) dut (.sys_clk(sys_clk), .nrst(nrst),
    .port_select_n(sel_n), .address_latch_strobe(ale),
    .port_read_strobe_n(rd_n), .port_write_strobe_n(wr_n),
    .multiplexed_ad_bus_in(ad_in), .multiplexed_ad_bus_out(bus_out),
    .multiplexed_ad_bus_oe(oe), .access_ack_n(ack_n), .mode_a(1'b1),
    .mode_b(1'b0), .mode_c(1'b1), .mem_req(req), .mem_we(we),
    .mem_pm(pm), .mem_addr(maddr), .mem_wdata(wdata), .mem_grant(grant),
    .mem_rdata(rdata), .core_dm_we(cdm_we), .core_dm_addr(cdm_addr),
    .core_dm_wdata(cdm_wdata), .core_ctrl_we(cctl_we),
    .overlay_sel(ovl), .core_hold(hold));
  hdma_mem_model u_mem (.sys_clk(sys_clk), .nrst(nrst), .mem_req(req),
    .mem_we(we), .mem_pm(pm), .mem_addr(maddr), .mem_wdata(wdata),
    .mem_grant(grant), .mem_rdata(rdata), .lat(lat));

  // 25 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic tick(int n = 1);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic complete_run;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic bad(string m);
    errors++;
    $display("MISMATCH at %0t: %s", $time, m);
  endtask
  task automatic chk_bus(logic [15:0] g, logic [15:0] e, string m);
    cmp_count++;
    if (g !== e) bad(m);
  endtask
  task automatic chk_mem(logic [23:0] g, logic [23:0] e, string m);
    cmp_count++;
    if (g !== e) bad(m);
  endtask
  // Bounded wait for the port to accept an operation
  task automatic wait_ack;
    for (int i = 0; i < 400 && ack_n !== 1'b0; i++) tick();
    if (ack_n !== 1'b0) begin
      bad("ack timeout");
      complete_run();
    end
  endtask
  // Host cycles; bus inverted once its hold time is over
  // by_sel latches on select release while the latch strobe is high
  task automatic host_latch(logic [15:0] w, logic by_sel = 1'b0);
    wait_ack();
    sel_n <= 1'b0;
    ad_in <= w;
    ale <= 1'b1;
    tick(4);
    if (by_sel) begin
      sel_n <= 1'b1;
    end else begin
      ale <= 1'b0;
    end
    tick(4);
    sel_n <= 1'b1;
    ale <= 1'b0;
    ad_in <= ~w;
    tick(4);
  endtask
  task automatic host_write(logic [15:0] w);
    wait_ack();
    sel_n <= 1'b0;
    ad_in <= w;
    wr_n <= 1'b0;
    tick(4);
    wr_n <= 1'b1;
    tick(4);
    sel_n <= 1'b1;
    ad_in <= ~w;
    tick(4);
  endtask
  task automatic host_read(output logic [15:0] d);
    wait_ack();
    sel_n <= 1'b0;
    rd_n <= 1'b0;
    for (int i = 0; i < 400 && !(oe === 1'b1 && ack_n === 1'b0); i++)
      tick();
    if (!(oe === 1'b1 && ack_n === 1'b0)) begin
      bad("read timeout");
      complete_run();
    end
    d = bus_out;
    rd_n <= 1'b1;
    tick(4);
    sel_n <= 1'b1;
    tick(4);
  endtask
  task automatic core_wr(logic [13:0] a, logic [15:0] d, logic ctl);
    cdm_addr <= a;
    cdm_wdata <= d;
    cdm_we <= !ctl;
    cctl_we <= ctl;
    tick();
    cdm_we <= 1'b0;
    cctl_we <= 1'b0;
    tick(2);
  endtask

  // Boot through the port, 24-bit words in two halves
  task automatic t_boot_pm;
    chk_bus(hold, 1'b1, "core not held");
    host_latch(16'h0000);
    host_write(16'hABCD);
    host_write(16'h00EF);
    host_write(16'h1234);
    host_write(16'h0056);
    tick(10);
    chk_mem(u_mem.pm_mem[0], 24'hABCDEF, "pm word 0");
    chk_mem(u_mem.pm_mem[1], 24'h123456, "pm word 1");
    chk_bus(hold, 1'b0, "core still held");
    host_latch(16'h0000);
    host_read(rd_v);
    chk_bus(rd_v, 16'hABCD, "pm high");
    host_read(rd_v);
    chk_bus(rd_v, 16'h00EF, "pm low");
    core_wr(14'h3FE7, 16'h4000, 1'b0);
    host_read(rd_v);
    chk_bus(rd_v, 16'h1234, "pm next high");
    host_read(rd_v);
    chk_bus(rd_v, 16'h0056, "pm short low");
    $display("Test boot_pm done");
  endtask
  // Slow memory fills the buffer; no word may be lost
  task automatic t_dm_block;
    lat <= 8'h3C;
    host_latch(16'h4010);
    for (int i = 0; i < 4; i++) host_write(16'h1111 * (i + 1));
    lat <= 8'h03;
    host_latch(16'h4010, 1'b1);
    for (int i = 0; i < 4; i++) begin
      chk_bus(u_mem.dm_mem[16 + i][15:0], 16'h1111 * (i + 1), "dm wr");
      host_read(rd_v);
      chk_bus(rd_v, 16'h1111 * (i + 1), "dm rd");
    end
    $display("Test dm_block done");
  endtask
  // Writes stop at the control register range
  task automatic t_mmr;
    host_latch(16'h7FDF);
    host_write(16'h5A5A);
    host_write(16'hA5A5);
    tick(20);
    chk_bus(u_mem.dm_mem[14'h3FDF][15:0], 16'h5A5A, "dm 3FDF");
    chk_mem(u_mem.dm_mem[14'h3FE0], 24'h000000, "mmr written");
    chk_bus(ovl, 16'h0000, "overlay touched");
    $display("Test mmr done");
  endtask
  // Overlay from core and host, and core-set start address
  task automatic t_overlay;
    core_wr(14'h3FE0, 16'h00A5, 1'b0);
    chk_bus(ovl, 16'h00A5, "core overlay");
    host_latch(16'h8000);
    chk_bus(ovl, 16'h0000, "host overlay");
    core_wr(14'h0000, 16'h803C, 1'b1);
    chk_bus(ovl, 16'h003C, "ctl overlay");
    core_wr(14'h0000, 16'h4011, 1'b1);
    host_read(rd_v);
    chk_bus(rd_v, 16'h2222, "ctl address");
    $display("Test overlay done");
  endtask

  initial begin
    nrst = 1'b0;
    {sel_n, rd_n, wr_n, ale, cdm_we, cctl_we} = 6'h38;
    ad_in = 16'h0000;
    cdm_addr = 14'h0000;
    cdm_wdata = 16'h0000;
    lat = 8'h00;
    errors = 0;
    cmp_count = 0;
    tick(20);
    nrst <= 1'b1;
    tick(5);
    t_boot_pm();
    t_dm_block();
    t_mmr();
    t_overlay();
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
